// ---- common/dram_bank_params.svh ----
// Constants for the bank interleave and support logic of the memory controller.
// Assumes inclusion by bare name from the package and the design files.
// What this block does
// - With subpage activation, sub-row select bits copy mapped top sub-column bits.
// - Each bank performs only one read, write or refresh at a time.
// - Four, eight or sixteen banks per channel are supported.
// - A busy bank gets no further access until its current one completes.
// - Queued commands for free banks issue while another bank is busy.
// - Sixteen banks: 128-byte blocks go round-robin, bank n gets block n plus 16k.
// - Eight banks: real addresses interleave across eight banks in 128-byte blocks.
// - Scheduling always works on sixteen logical banks.
// - Eight physical banks: each physical bank serves two logical banks.
// - Token allocation uses the same logical bank definition as the scheduler.
// - Restart means taking the DRAM devices out of power-down.
// - One setup write allows repeated polling reads of the same I/O cell register.
`ifndef DRAM_BANK_PARAMS_SVH
`define DRAM_BANK_PARAMS_SVH
`define BLOCK_OFF_W 7
`define LBANK_W 4
`define NUM_LBANKS 16
`define SUBCOL_LSB 2
`define SUBCOL_W 5
`define SUBROW_W 2
`define MAP_W 3
`define IND_DATA_W 32
`define IND_RD_BIT 3
`define IND_ADDR_LSB 8
`define IND_ADDR_W 8
`endif

// ---- common/dram_bank_pkg.sv ----
// Types shared by the bank interleave controller and its bank trackers.
// Assumes the constants header sits beside this file.
`include "dram_bank_params.svh"
package dram_bank_pkg;
  // Physical bank count per channel, chosen by configuration.
  typedef enum logic [1:0] {BANKS_4, BANKS_8, BANKS_16} bank_count_e;
  // Operation kinds that occupy a bank.
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_REFRESH} op_e;
  // Power-down sequencing states.
  typedef enum logic [1:0] {PD_RUN, PD_DRAIN, PD_DOWN} pd_state_e;
endpackage : dram_bank_pkg

// ---- design/bank_tracker.sv ----
// One physical bank's occupancy flag.
// Assumes issue and completion pulses come from logic on the same clock.
module bank_tracker
  import dram_bank_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Occupancy events.
  input wire logic start,
  input wire logic finish,
  // State.
  output logic busy
);
  // A new start wins over a finish in the same cycle, so an access is never forgotten.
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (finish) begin
      busy <= 1'b0;
    end
  end
endmodule : bank_tracker

// ---- design/dram_bank_interleave_ctrl.sv ----
// Bank mapping, per-bank scheduling, power-down stop and restart, and indirect
// I/O cell register reads for one memory channel.
// Assumes requests, completions and the I/O cell port all run on clk.
`include "dram_bank_params.svh"
module dram_bank_interleave_ctrl
  import dram_bank_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int QDEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Static configuration.
  input wire bank_count_e cfg_bank_count,
  input wire logic cfg_subpage_en,
  input wire logic [`MAP_W-1:0] cfg_sr0_map,
  input wire logic [`MAP_W-1:0] cfg_sr1_map,
  input wire logic init_done,
  // Memory requests from the bus side.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_write,
  // Refresh requests for one physical bank.
  input wire logic refresh_valid,
  output logic refresh_ready,
  input wire logic [`LBANK_W-1:0] refresh_bank,
  // Commands toward the DRAM I/O cell.
  output logic cmd_valid,
  input wire logic cmd_ready,
  output op_e cmd_op,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [`LBANK_W-1:0] cmd_lbank,
  output logic [`LBANK_W-1:0] cmd_pbank,
  output logic [`SUBROW_W-1:0] subrow_select_bits,
  // Completion of an access on a physical bank.
  input wire logic done_valid,
  input wire logic [`LBANK_W-1:0] done_pbank,
  // Token allocator bank lookup.
  input wire logic [ADDR_W-1:0] tok_addr,
  output logic [`LBANK_W-1:0] tok_lbank,
  // Power-down stop and restart.
  input wire logic pd_enter,
  input wire logic pd_exit,
  output logic dram_powerdown,
  // Indirect I/O cell register access.
  input wire logic ind_wr,
  input wire logic [`IND_DATA_W-1:0] ind_wr_data,
  input wire logic ind_rd,
  output logic ind_rd_done,
  output logic ind_rd_err,
  output logic [`IND_DATA_W-1:0] ind_rd_data,
  output logic io_rd_valid,
  output logic [`IND_ADDR_W-1:0] io_rd_addr,
  input wire logic io_rd_ack,
  input wire logic [`IND_DATA_W-1:0] io_rd_data
);
  localparam int QI_W = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;

  // Refuse shapes the mapping cannot serve; this stops elaboration, not simulation.
  if (ADDR_W < `BLOCK_OFF_W + `LBANK_W + 1 || QDEPTH < 1 || QDEPTH > 16) begin : g_bad_shape
    $error("dram_bank_interleave_ctrl: unsupported ADDR_W or QDEPTH");
  end

  // Logical bank from address: the bits right above the 128-byte block offset.
  function automatic logic [`LBANK_W-1:0] lbank_of(input logic [ADDR_W-1:0] a);
    lbank_of = a[`BLOCK_OFF_W +: `LBANK_W];
  endfunction : lbank_of

  // Logical to physical bank; smaller parts fold logical banks together.
  function automatic logic [`LBANK_W-1:0] pbank_of(input logic [`LBANK_W-1:0] lb,
                                                   input bank_count_e cnt);
    case (cnt)
      BANKS_16: pbank_of = lb;
      BANKS_8: pbank_of = {1'b0, lb[2:0]};
      default: pbank_of = {2'b00, lb[1:0]};
    endcase
  endfunction : pbank_of

  // Pending command slots, each remembering its address and direction.
  logic [QDEPTH-1:0] slot_valid;
  logic [ADDR_W-1:0] slot_addr [QDEPTH];
  logic slot_write [QDEPTH];
  logic [`NUM_LBANKS-1:0] busy;
  logic [`NUM_LBANKS-1:0] start_vec;
  logic [`NUM_LBANKS-1:0] finish_vec;
  pd_state_e pd_state;
  logic running;
  logic can_load;
  logic free_found;
  logic [QI_W-1:0] free_idx;
  logic pick_found;
  logic [QI_W-1:0] pick_idx;
  logic do_refresh;
  logic do_issue;
  logic [`LBANK_W-1:0] issue_pbank;

  // Traffic flows only after initialization and outside power-down.
  assign running = init_done && (pd_state == PD_RUN);
  assign can_load = running && (!cmd_valid || cmd_ready);

  // Lowest free slot takes the next request.
  always_comb begin
    free_found = 1'b0;
    free_idx = '0;
    for (int i = QDEPTH - 1; i >= 0; i--) begin
      if (!slot_valid[i]) begin
        free_found = 1'b1;
        free_idx = QI_W'(i);
      end
    end
  end

  // Lowest slot whose physical bank is idle issues; busy banks are skipped.
  always_comb begin
    pick_found = 1'b0;
    pick_idx = '0;
    for (int i = QDEPTH - 1; i >= 0; i--) begin
      if (slot_valid[i] && !busy[pbank_of(lbank_of(slot_addr[i]), cfg_bank_count)]) begin
        pick_found = 1'b1;
        pick_idx = QI_W'(i);
      end
    end
  end

  // Refresh of an idle bank goes ahead of queued traffic so no row decays.
  assign do_refresh = can_load && refresh_valid && !busy[refresh_bank];
  assign do_issue = can_load && !do_refresh && pick_found;
  assign refresh_ready = do_refresh;
  assign req_ready = init_done && free_found;
  assign issue_pbank = do_refresh ? refresh_bank :
                       pbank_of(lbank_of(slot_addr[pick_idx]), cfg_bank_count);

  // Slot bookkeeping: fill on accept, empty on issue.
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_valid <= '0;
    end else begin
      for (int i = 0; i < QDEPTH; i++) begin
        if (req_valid && req_ready && free_idx == QI_W'(i)) begin
          slot_valid[i] <= 1'b1;
          slot_addr[i] <= req_addr;
          slot_write[i] <= req_write;
        end else if (do_issue && pick_idx == QI_W'(i)) begin
          slot_valid[i] <= 1'b0;
        end
      end
    end
  end

  // Busy vector updates per physical bank.
  always_comb begin
    start_vec = '0;
    finish_vec = '0;
    if (do_refresh || do_issue) begin
      start_vec[issue_pbank] = 1'b1;
    end
    if (done_valid) begin
      finish_vec[done_pbank] = 1'b1;
    end
  end

  // One tracker per physical bank; all sixteen exist for the widest part.
  for (genvar b = 0; b < `NUM_LBANKS; b++) begin : g_bank
    bank_tracker u_trk (
      .clk(clk),
      .reset(reset),
      .start(start_vec[b]),
      .finish(finish_vec[b]),
      .busy(busy[b])
    );
  end

  // Sub-row select copies the two mapped sub-column bits of the address.
  function automatic logic subrow_bit(input logic [ADDR_W-1:0] a, input logic [`MAP_W-1:0] m);
    logic [`SUBCOL_W-1:0] subcolumn_bits;
    subcolumn_bits = a[`SUBCOL_LSB +: `SUBCOL_W];
    subrow_bit = (m < `MAP_W'(`SUBCOL_W)) ? subcolumn_bits[m] : 1'b0;
  endfunction : subrow_bit

  // Command register, held until the I/O cell takes it.
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_valid <= 1'b0;
      cmd_op <= OP_READ;
      cmd_addr <= '0;
      cmd_lbank <= '0;
      cmd_pbank <= '0;
      subrow_select_bits <= '0;
    end else if (do_refresh) begin
      cmd_valid <= 1'b1;
      cmd_op <= OP_REFRESH;
      cmd_addr <= '0;
      cmd_lbank <= refresh_bank;
      cmd_pbank <= refresh_bank;
      subrow_select_bits <= '0;
    end else if (do_issue) begin
      cmd_valid <= 1'b1;
      cmd_op <= slot_write[pick_idx] ? OP_WRITE : OP_READ;
      cmd_addr <= slot_addr[pick_idx];
      cmd_lbank <= lbank_of(slot_addr[pick_idx]);
      cmd_pbank <= issue_pbank;
      if (cfg_subpage_en) begin
        subrow_select_bits <= {subrow_bit(slot_addr[pick_idx], cfg_sr1_map),
                               subrow_bit(slot_addr[pick_idx], cfg_sr0_map)};
      end else begin
        subrow_select_bits <= '0;
      end
    end else if (cmd_ready) begin
      cmd_valid <= 1'b0;
    end
  end

  // Token allocator sees the same logical bank split as the scheduler.
  always_ff @(posedge clk) begin
    if (reset) begin
      tok_lbank <= '0;
    end else begin
      tok_lbank <= lbank_of(tok_addr);
    end
  end

  // Stop drains outstanding work before power-down, since refresh must not be cut.
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_state <= PD_RUN;
    end else begin
      case (pd_state)
        PD_RUN: begin
          if (pd_enter) begin
            pd_state <= PD_DRAIN;
          end
        end
        PD_DRAIN: begin
          if (busy == '0 && !cmd_valid) begin
            pd_state <= PD_DOWN;
          end
        end
        PD_DOWN: begin
          if (pd_exit) begin
            pd_state <= PD_RUN;
          end
        end
        default: pd_state <= PD_RUN;
      endcase
    end
  end

  // Devices are told to power down only once the drain is over.
  always_ff @(posedge clk) begin
    if (reset) begin
      dram_powerdown <= 1'b0;
    end else begin
      dram_powerdown <= (pd_state == PD_DOWN) && !pd_exit;
    end
  end

  // Indirect access: the setup stays armed so software can poll one register.
  logic ind_armed;
  always_ff @(posedge clk) begin
    if (reset) begin
      ind_armed <= 1'b0;
      io_rd_addr <= '0;
    end else if (ind_wr) begin
      ind_armed <= ind_wr_data[`IND_RD_BIT];
      io_rd_addr <= ind_wr_data[`IND_ADDR_LSB +: `IND_ADDR_W];
    end
  end

  // An armed read with no read outstanding goes to the I/O cell, an unarmed one returns an error; arming is kept for the next poll.
  always_ff @(posedge clk) begin
    if (reset) begin
      io_rd_valid <= 1'b0;
      ind_rd_done <= 1'b0;
      ind_rd_err <= 1'b0;
      ind_rd_data <= '0;
    end else begin
      ind_rd_done <= 1'b0;
      ind_rd_err <= 1'b0;
      if (io_rd_valid && io_rd_ack) begin
        io_rd_valid <= 1'b0;
        ind_rd_done <= 1'b1;
        ind_rd_data <= io_rd_data;
      end else if (ind_rd && !io_rd_valid) begin
        if (ind_armed) begin
          io_rd_valid <= 1'b1;
        end else begin
          ind_rd_done <= 1'b1;
          ind_rd_err <= 1'b1;
          ind_rd_data <= '0;
        end
      end
    end
  end
endmodule : dram_bank_interleave_ctrl

// ---- tb/dram_bank_sva.sv ----
// Port-level checker for the bank interleave controller, bound after the module.
// Assumes one clock and a synchronous active-high reset on every port watched.
module dram_bank_sva
  import dram_bank_pkg::*;
(
  // Clock, reset and configuration.
  input wire logic clk, reset,
  input wire bank_count_e cfg_bank_count,
  // Commands, completions and power-down.
  input wire logic cmd_valid, cmd_ready, done_valid, pd_exit, dram_powerdown,
  input wire op_e cmd_op,
  input wire logic [31:0] cmd_addr,
  input wire logic [3:0] cmd_lbank, cmd_pbank, done_pbank,
  // Indirect register access.
  input wire logic ind_wr, ind_rd, ind_rd_done, ind_rd_err, io_rd_valid, io_rd_ack,
  input wire logic [31:0] ind_wr_data, ind_rd_data, io_rd_data,
  input wire logic [7:0] io_rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busy;
  logic armed;
  logic [7:0] addr_h;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // A bank counts as taken from acceptance until the far side reports it done.
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 16'h0000;
    end else begin
      busy <= (busy & ~(16'(done_valid) << done_pbank))
        | (16'(cmd_valid && cmd_ready) << cmd_pbank);
    end
  end
  // Every setup write decides arming and address; a write without the read bit disarms.
  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (ind_wr) begin
      armed <= ind_wr_data[3];
      addr_h <= ind_wr_data[15:8];
    end
  end
  a_lbank_from_addr: assert property (
    cmd_valid && cmd_op != OP_REFRESH |-> cmd_lbank == cmd_addr[10:7])
    else $error("logical bank not taken from address");
  a_pbank_fold: assert property (
    cmd_valid && cmd_op != OP_REFRESH |-> cmd_pbank == (cmd_lbank &
    (cfg_bank_count == BANKS_16 ? 4'hf : cfg_bank_count == BANKS_8 ? 4'h7 : 4'h3)))
    else $error("physical bank fold wrong");
  a_busy_bank_held: assert property (
    cmd_valid && ($past(cmd_ready) || !$past(cmd_valid)) |-> !busy[cmd_pbank])
    else $error("command issued to a busy bank");
  a_powerdown_quiet: assert property (dram_powerdown |-> !cmd_valid)
    else $error("command while powered down");
  a_powerdown_exit: assert property (dram_powerdown && pd_exit |=> !dram_powerdown)
    else $error("power-down not left");
  a_unarmed_refuse: assert property (
    ind_rd && !io_rd_valid && !armed |=> ind_rd_done && ind_rd_err)
    else $error("unarmed read not refused");
  a_poll_issue: assert property (
    ind_rd && !io_rd_valid && armed |=> io_rd_valid && io_rd_addr == addr_h)
    else $error("armed read not issued");
  a_poll_return: assert property (
    io_rd_valid && io_rd_ack |=> ind_rd_done && !ind_rd_err && ind_rd_data == $past(io_rd_data))
    else $error("read data not returned");
  c_overlap: cover property (cmd_valid && cmd_ready && busy != 16'h0000);
  c_powerdown: cover property ($rose(dram_powerdown));
  c_poll: cover property (io_rd_valid && io_rd_ack);
endmodule : dram_bank_sva

bind dram_bank_interleave_ctrl dram_bank_sva dram_bank_sva_i (.*);

// ---- tb/dram_far_side.sv ----
// Far-side model: DRAM banks behind the I/O cell, and the cell's register file.
// Assumes every handshake is sampled on the rising edge of clk.
module dram_far_side (
  // Clock, reset and pacing.
  input wire logic clk, reset, slow,
  // Commands and completions.
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_pbank,
  output logic cmd_ready, done_valid,
  output logic [3:0] done_pbank,
  // Register reads.
  input wire logic io_rd_valid,
  input wire logic [7:0] io_rd_addr,
  output logic io_rd_ack,
  output logic [31:0] io_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int now;
  int due[$];
  logic [3:0] bank_q[$];
  logic take;
  assign take = io_rd_valid && !io_rd_ack && now[0];
  initial {cmd_ready, done_valid, done_pbank, io_rd_ack, io_rd_data} = '0;
  // Ready drops one cycle in three; idle lines show changing junk, not a held value.
  always @(posedge clk) begin
    now <= now + 1;
    cmd_ready <= !reset && now % 3 != 0;
    done_valid <= 1'b0;
    done_pbank <= ~done_pbank;
    io_rd_ack <= take;
    io_rd_data <= take ? {4{io_rd_addr}} : ~io_rd_data;
    if (reset) begin
      due.delete();
      bank_q.delete();
    end else if (cmd_valid && cmd_ready) begin
      due.push_back(now + (slow ? 24 : 3));
      bank_q.push_back(cmd_pbank);
    end
    if (due.size() > 0 && due[0] <= now) begin
      void'(due.pop_front());
      done_valid <= 1'b1;
      done_pbank <= bank_q.pop_front();
    end
  end
endmodule : dram_far_side

// ---- tb/dram_bank_interleave_ctrl_bench.sv ----
// Self-checking bench for the bank interleave controller and its far-side model.
// Assumes the checker binds itself and the package is compiled first.
module dram_bank_interleave_ctrl_bench
  import dram_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cfg_subpage_en, init_done, req_valid, req_write, refresh_valid, slow;
  logic req_ready, refresh_ready, cmd_valid, cmd_ready, done_valid, pd_enter, pd_exit;
  logic dram_powerdown, ind_wr, ind_rd, ind_rd_done, ind_rd_err, io_rd_valid, io_rd_ack;
  logic [31:0] req_addr, tok_addr, cmd_addr, ind_wr_data, ind_rd_data, io_rd_data, prev_tok;
  logic [3:0] refresh_bank, cmd_lbank, cmd_pbank, done_pbank, tok_lbank;
  logic [2:0] cfg_sr0_map, cfg_sr1_map;
  logic [1:0] subrow_select_bits;
  logic [7:0] io_rd_addr;
  logic [3:0] lb[$];
  bank_count_e cfg_bank_count;
  op_e cmd_op;
  int seed, fail_count, n_tests, sent, issued, refs, cycles, s, k;
  dram_bank_interleave_ctrl dram_bank_interleave_ctrl_i (.*);
  dram_far_side dram_far_side_i (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Leaves the request raised so back-to-back sends never retouch it in one step.
  task automatic send(input logic [31:0] a);
    req_addr <= a;
    tok_addr <= a;
    req_write <= a[2];
    req_valid <= 1'b1;
    do tick(1); while (req_ready !== 1'b1);
    sent++;
  endtask : send
  task automatic drain(input string name);
    req_valid <= 1'b0;
    tick(1);
    for (k = 0; k < 400 && issued != sent; k++) tick(1);
    check("issued", issued, sent);
    $display("test %s done", name);
  endtask : drain
  task automatic rd;
    ind_rd <= 1'b1;
    tick(1);
    ind_rd <= 1'b0;
    for (k = 0; k < 50 && ind_rd_done !== 1'b1; k++) tick(1);
    check("rd_done", ind_rd_done, 1);
  endtask : rd
  function automatic logic [3:0] exp_pbank(input logic [31:0] a);
    return a[10:7] & (cfg_bank_count == BANKS_16 ? 4'hf : cfg_bank_count == BANKS_8 ? 4'h7 : 4'h3);
  endfunction : exp_pbank
  // Sub-row bits copy the mapped sub-column bits; an unused index or no subpage gives zero.
  function automatic logic [1:0] exp_subrow(input logic [31:0] a);
    logic [4:0] sc;
    sc = a[6:2];
    if (!cfg_subpage_en) return 2'b00;
    return {cfg_sr1_map < 5 ? sc[cfg_sr1_map] : 1'b0, cfg_sr0_map < 5 ? sc[cfg_sr0_map] : 1'b0};
  endfunction : exp_subrow
  // Every accepted read or write is compared against the mapping worked out from its address; refreshes against refresh_bank.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    prev_tok <= tok_addr;
    if (!reset) check("tok_lbank", tok_lbank, prev_tok[10:7]);
    if (cmd_valid && cmd_ready) begin
      issued++;
      lb.push_back(cmd_lbank);
      if (cmd_op == OP_REFRESH) begin
        refs++;
        check("refresh_bank", cmd_pbank, refresh_bank);
      end else begin
        check("op", cmd_op, cmd_addr[2] ? OP_WRITE : OP_READ);
        check("pbank", cmd_pbank, exp_pbank(cmd_addr));
        check("subrow", subrow_select_bits, exp_subrow(cmd_addr));
      end
    end
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    seed = 32'h3bfb_48ce;
    {reset, cfg_subpage_en, init_done, req_valid, req_write, refresh_valid, slow} = 7'h60;
    {pd_enter, pd_exit, ind_wr, ind_rd, cfg_sr0_map, cfg_sr1_map, refresh_bank} = '0;
    {req_addr, tok_addr, ind_wr_data} = '0;
    cfg_bank_count = BANKS_4;
    tick(5);
    reset <= 1'b0;
    tick(2);
    check("ready_before_init", req_ready, 0);
    init_done <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      cfg_bank_count <= bank_count_e'(c);
      cfg_subpage_en <= (c != 1);
      cfg_sr0_map <= 3'(c + 2);
      cfg_sr1_map <= 3'(c * 2 + 1);
      repeat (12) send($random(seed));
      drain("mapping");
    end
    // Two accesses to one bank with a third bank behind them, far side slow.
    slow <= 1'b1;
    // Let earlier completions land so the shared bank starts idle.
    tick(30);
    s = lb.size();
    send(32'h0000_0180);
    send(32'h0001_0180);
    send(32'h0000_0480);
    drain("busy_bank");
    check("second_issue", lb[s + 1], 9);
    check("third_issue", lb[s + 2], 3);
    refresh_bank <= 4'h5;
    refresh_valid <= 1'b1;
    do tick(1); while (refresh_ready !== 1'b1);
    refresh_valid <= 1'b0;
    sent++;
    drain("refresh");
    check("refresh_op", refs, 1);
    slow <= 1'b0;
    pd_enter <= 1'b1;
    tick(1);
    pd_enter <= 1'b0;
    for (k = 0; k < 100 && dram_powerdown !== 1'b1; k++) tick(1);
    check("powered_down", dram_powerdown, 1);
    send(32'h0000_0200);
    req_valid <= 1'b0;
    tick(4);
    check("held_while_down", cmd_valid, 0);
    pd_exit <= 1'b1;
    tick(1);
    pd_exit <= 1'b0;
    tick(1);
    check("restarted", dram_powerdown, 0);
    drain("power");
    rd();
    check("unarmed_err", ind_rd_err, 1);
    ind_wr_data <= 32'h0000_5a08;
    ind_wr <= 1'b1;
    tick(1);
    ind_wr <= 1'b0;
    repeat (3) begin
      rd();
      check("poll_data", ind_rd_data, 32'h5a5a_5a5a);
      check("poll_err", ind_rd_err, 0);
    end
    $display("test indirect done");
    conclude();
  end
endmodule : dram_bank_interleave_ctrl_bench
